// *** core/stfp_defines.vh ***
`ifndef STFP_DEFINES_VH
`define STFP_DEFINES_VH

// ********************************
// word length codes
// ********************************
`define STFP_WL_8              2'b00
`define STFP_WL_9              2'b01
`define STFP_WL_7              2'b10
`define STFP_LEN_7             4'h7
`define STFP_LEN_8             4'h8
`define STFP_LEN_9             4'h9

// ********************************
// stop bit codes and lengths in half bits
// ********************************
`define STFP_STOP_1            2'b00
`define STFP_STOP_0P5          2'b01
`define STFP_STOP_2            2'b10
`define STFP_STOP_1P5          2'b11
`define STFP_HALVES_1          3'h2
`define STFP_HALVES_0P5        3'h1
`define STFP_HALVES_2          3'h4
`define STFP_HALVES_1P5        3'h3

// ********************************
// timing
// ********************************
`define STFP_HALVES_PER_BIT    3'h2
`define STFP_DIV_RESET         16'h0001

// ********************************
// reset values
// ********************************
`define STFP_CHAR_RESET        9'h1ff

`endif

// *** core/stfp_half_tick.v ***
`timescale 1ns/1ps
`include "stfp_defines.vh"

// ********************************
// half-bit enable divider
// ********************************
module stfp_half_tick (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        run,
  input  wire        restart,
  input  wire [15:0] half_bit_divisor,
  output reg         half_tick
);

  reg  [15:0] count;
  wire [15:0] limit;

  // a divisor of zero would wrap and tick only every 65536 cycles, so it acts as one
  assign limit = (half_bit_divisor == 16'h0000) ? `STFP_DIV_RESET
                                                : half_bit_divisor;

  always @(posedge ref_clk) begin
    if (rst || !run) begin
      count     <= 16'h0000;
      half_tick <= 1'b0;
    end else if (restart) begin
      // preloaded so the first half bit after a restart is a full one
      count     <= (limit == 16'h0001) ? 16'h0000 : 16'h0001;
      half_tick <= (limit == 16'h0001);
    end else if (count == limit - 16'h0001) begin
      count     <= 16'h0000;
      half_tick <= 1'b1;
    end else begin
      count     <= count + 16'h0001;
      half_tick <= 1'b0;
    end
  end

endmodule

// *** core/stfp_tx_frame.v ***
`timescale 1ns/1ps
`include "stfp_defines.vh"

module stfp_tx_frame (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        module_enable,
  input  wire        transmitter_enable,
  input  wire [1:0]  word_length_select,
  input  wire        parity_enable,
  input  wire        parity_select,
  input  wire [1:0]  stop_bits_select,
  input  wire        half_duplex_enable,
  input  wire        sync_clock_out_enable,
  input  wire [15:0] half_bit_divisor,
  input  wire [8:0]  transmit_data_reg,
  input  wire        transmit_data_write,
  input  wire        break_request_set,
  input  wire        break_request_cancel,
  input  wire        transmit_complete_clear,
  input  wire        transmit_empty_irq_enable,
  input  wire        transmit_complete_irq_enable,
  input  wire [8:0]  rx_char,
  input  wire        rx_char_done,
  input  wire        parity_error_clear,
  input  wire        parity_error_irq_enable,
  input  wire        rx_pin,
  input  wire        tx_pin_in,
  output reg         tx_pin_out,
  output reg         tx_pin_oe,
  output reg         serial_clock_out_pin,
  output reg         receive_line,
  output reg         break_send_request,
  output reg         transmit_buffer_empty_flag,
  output reg         transmit_complete_flag,
  output reg         parity_error_flag,
  output wire        transmit_empty_irq,
  output wire        transmit_complete_irq,
  output wire        parity_error_irq,
  output wire        tx_busy
);

  // ********************************
  // states and frame kinds
  // ********************************
  localparam ST_IDLE  = 2'b00;
  localparam ST_START = 2'b01;
  localparam ST_DATA  = 2'b10;
  localparam ST_STOP  = 2'b11;

  localparam K_DATA   = 2'b00;
  localparam K_IDLE   = 2'b01;
  localparam K_BREAK  = 2'b10;

  // ********************************
  // functions
  // ********************************
  function [3:0] char_len;
    input [1:0] wl;
    begin
      if (wl == `STFP_WL_9) begin
        char_len = `STFP_LEN_9;
      end else if (wl == `STFP_WL_7) begin
        char_len = `STFP_LEN_7;
      end else begin
        char_len = `STFP_LEN_8;
      end
    end
  endfunction

  // xor of the bits below len, inverted for odd parity
  function parity_of;
    input [8:0] data;
    input [3:0] len;
    input       odd;
    integer     i;
    reg         acc;
    begin
      acc = odd;
      for (i = 0; i < 9; i = i + 1) begin
        if (i < len) begin
          acc = acc ^ data[i];
        end
      end
      parity_of = acc;
    end
  endfunction

  function [8:0] build_char;
    input [8:0] data;
    input [3:0] len;
    input       pen;
    input       odd;
    reg   [8:0] c;
    reg   [3:0] msb;
    begin
      c   = data;
      msb = len - 4'h1;
      if (pen) begin
        c[msb] = parity_of(data, msb, odd);
      end
      build_char = c;
    end
  endfunction

  function [2:0] stop_halves;
    input [1:0] sel;
    begin
      if (sel == `STFP_STOP_0P5) begin
        stop_halves = `STFP_HALVES_0P5;
      end else if (sel == `STFP_STOP_2) begin
        stop_halves = `STFP_HALVES_2;
      end else if (sel == `STFP_STOP_1P5) begin
        stop_halves = `STFP_HALVES_1P5;
      end else begin
        stop_halves = `STFP_HALVES_1;
      end
    end
  endfunction

  // ********************************
  // state
  // ********************************
  reg  [1:0] state;
  reg  [1:0] kind;
  reg  [8:0] shreg;
  reg  [3:0] bits_left;
  reg  [2:0] half_cnt;
  reg  [2:0] stop_len;
  reg  [8:0] buffer;
  reg        buffer_full;
  reg        pend_idle;
  reg        active_q;
  reg        rx_s1;
  reg        rx_s2;
  reg        rx_s3;
  wire       active;
  wire       half_tick;
  wire       frame_end;
  wire [3:0] len_now;

  assign active    = module_enable & transmitter_enable;
  assign len_now   = char_len(word_length_select);
  assign tx_busy   = (state != ST_IDLE);
  assign frame_end = (state == ST_STOP) && half_tick &&
                     (half_cnt + 3'h1 == stop_len);

  assign transmit_empty_irq    = transmit_buffer_empty_flag &
                                 transmit_empty_irq_enable;
  assign transmit_complete_irq = transmit_complete_flag &
                                 transmit_complete_irq_enable;
  assign parity_error_irq      = parity_error_flag &
                                 parity_error_irq_enable;

  stfp_half_tick u_tick (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .run              (active),
    .restart          (~tx_busy), // held while idle: full start bit
    .half_bit_divisor (half_bit_divisor),
    .half_tick        (half_tick)
  );

  // ********************************
  // transmit engine
  // ********************************
  always @(posedge ref_clk) begin
    if (rst) begin
      state                      <= ST_IDLE;
      kind                       <= K_DATA;
      shreg                      <= `STFP_CHAR_RESET;
      bits_left                  <= 4'h0;
      half_cnt                   <= 3'h0;
      stop_len                   <= `STFP_HALVES_1;
      buffer                     <= 9'h000;
      buffer_full                <= 1'b0;
      pend_idle                  <= 1'b0;
      active_q                   <= 1'b0;
      break_send_request         <= 1'b0;
      transmit_buffer_empty_flag <= 1'b1;
      transmit_complete_flag     <= 1'b1;
    end else begin
      active_q    <= active;
      if (active && !active_q) begin
        pend_idle <= 1'b1;
      end
      // clearing the enable mid frame drops it: software must not
      if (!active) begin
        state     <= ST_IDLE;
        pend_idle <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (pend_idle) begin
              kind      <= K_IDLE;
              pend_idle <= 1'b0;
              stop_len  <= stop_halves(stop_bits_select);
              state     <= ST_START;
            end else if (break_send_request) begin
              kind     <= K_BREAK;
              shreg    <= 9'h000;
              stop_len <= (stop_bits_select == `STFP_STOP_2) ?
                          `STFP_HALVES_2 : `STFP_HALVES_1;
              state    <= ST_START;
            end else if (buffer_full) begin
              kind        <= K_DATA;
              shreg       <= build_char(buffer, len_now, parity_enable,
                                        parity_select);
              stop_len    <= stop_halves(stop_bits_select);
              buffer_full <= 1'b0;
              transmit_buffer_empty_flag <= 1'b1;
              state       <= ST_START;
            end
            half_cnt  <= 3'h0;
            bits_left <= len_now;
          end
          ST_START: begin
            if (half_tick) begin
              if (half_cnt == `STFP_HALVES_PER_BIT - 3'h1) begin
                half_cnt <= 3'h0;
                state    <= ST_DATA;
              end else begin
                half_cnt <= half_cnt + 3'h1;
              end
            end
          end
          ST_DATA: begin
            if (half_tick) begin
              if (half_cnt == `STFP_HALVES_PER_BIT - 3'h1) begin
                half_cnt  <= 3'h0;
                shreg     <= {1'b1, shreg[8:1]};
                bits_left <= bits_left - 4'h1;
                if (bits_left == 4'h1) begin
                  state <= ST_STOP;
                  if (kind == K_BREAK) begin
                    break_send_request <= 1'b0;
                  end
                end
              end else begin
                half_cnt <= half_cnt + 3'h1;
              end
            end
          end
          default: begin
            if (half_tick) begin
              half_cnt <= half_cnt + 3'h1;
              if (half_cnt + 3'h1 == stop_len) begin
                state <= ST_IDLE;
              end
            end
          end
        endcase
      end

      if (transmit_complete_clear || transmit_data_write) begin
        transmit_complete_flag <= 1'b0;
      end
      if (frame_end && !buffer_full && kind != K_IDLE) begin
        transmit_complete_flag <= 1'b1;
      end

      // a write held while a frame runs; idle engine takes it next cycle
      if (transmit_data_write) begin
        buffer                     <= transmit_data_reg;
        buffer_full                <= 1'b1;
        transmit_buffer_empty_flag <= 1'b0;
      end
      if (break_request_cancel) begin
        break_send_request <= 1'b0;
      end
      if (break_request_set) begin
        break_send_request <= 1'b1;
      end
    end
  end

  // ********************************
  // line drive and clock out
  // ********************************
  reg line;

  always @* begin
    if (state == ST_START) begin
      line = (kind == K_IDLE);
    end else if (state == ST_DATA) begin
      line = (kind == K_IDLE) | shreg[0];
    end else begin
      line = 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      tx_pin_out           <= 1'b1;
      tx_pin_oe            <= 1'b0;
      serial_clock_out_pin <= 1'b0;
    end else begin
      if (half_duplex_enable) begin
        tx_pin_out <= 1'b0;
        tx_pin_oe  <= active & ~line;
      end else begin
        tx_pin_out <= line;
        tx_pin_oe  <= active;
      end
      serial_clock_out_pin <= sync_clock_out_enable &
                              (state == ST_DATA) & half_cnt[0];
    end
  end

  // ********************************
  // receive line and parity check
  // ********************************
  always @(posedge ref_clk) begin
    if (rst) begin
      rx_s1        <= 1'b1;
      rx_s2        <= 1'b1;
      rx_s3        <= 1'b1;
      receive_line <= 1'b1;
    end else begin
      // rx pin is ignored in half duplex; tx wire loops back
      rx_s1 <= half_duplex_enable ? tx_pin_in : rx_pin;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) begin
        receive_line <= rx_s3;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      parity_error_flag <= 1'b0;
    end else begin
      if (parity_error_clear) begin
        parity_error_flag <= 1'b0;
      end
      if (rx_char_done && parity_enable &&
          parity_of(rx_char, len_now, parity_select)) begin
        parity_error_flag <= 1'b1;
      end
    end
  end

endmodule

// *** testbench/stfp_tx_frame_sva.sv ***
`timescale 1ns/1ps
// ******************************
// port checker
// ******************************
module stfp_tx_sva (
  input wire ref_clk,
  input wire rst,
  input wire tx_busy,
  input wire tx_pin_oe,
  input wire tx_pin_out,
  input wire transmit_data_write,
  input wire transmit_buffer_empty_flag,
  input wire transmit_complete_flag,
  input wire transmit_empty_irq,
  input wire transmit_empty_irq_enable,
  input wire transmit_complete_irq,
  input wire transmit_complete_irq_enable,
  input wire parity_error_clear,
  input wire rx_char_done,
  input wire parity_error_flag,
  input wire serial_clock_out_pin,
  input wire sync_clock_out_enable,
  input wire half_duplex_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_idle_high: assert property (
    !tx_busy && !$past(tx_busy) |-> !tx_pin_oe || tx_pin_out)
    else $error("line low while idle");
  a_write_clears: assert property (
    transmit_data_write |=> !transmit_buffer_empty_flag)
    else $error("empty flag kept after write");
  a_done_empty: assert property (
    $rose(transmit_complete_flag) |-> $past(transmit_buffer_empty_flag))
    else $error("complete with full buffer");
  a_empty_irq: assert property (
    transmit_empty_irq == (transmit_buffer_empty_flag
    && transmit_empty_irq_enable)) else $error("empty irq wrong");
  a_done_irq: assert property (
    transmit_complete_irq == (transmit_complete_flag
    && transmit_complete_irq_enable)) else $error("done irq wrong");
  a_perr_clear: assert property (
    parity_error_clear && !rx_char_done |=> !parity_error_flag)
    else $error("parity error not cleared");
  a_clk_gate: assert property (
    serial_clock_out_pin |-> $past(sync_clock_out_enable)
    && $past(tx_busy)) else $error("clock out of frame");
  a_open_drain: assert property (
    $past(half_duplex_enable) && tx_pin_oe |-> !tx_pin_out)
    else $error("line driven high in half duplex");
endmodule

bind stfp_tx_frame stfp_tx_sva u_sva (
  .ref_clk, .rst, .tx_busy, .tx_pin_oe, .tx_pin_out,
  .transmit_data_write, .transmit_buffer_empty_flag,
  .transmit_complete_flag, .transmit_empty_irq,
  .transmit_empty_irq_enable, .transmit_complete_irq,
  .transmit_complete_irq_enable, .parity_error_clear, .rx_char_done,
  .parity_error_flag, .serial_clock_out_pin, .sync_clock_out_enable,
  .half_duplex_enable
);

// *** testbench/stfp_remote_peer.sv ***
`timescale 1ns/1ps
// ******************************
// remote peer: samples the wire mid-bit
// ******************************
module stfp_remote_peer #(
  parameter int HALF = 2
) (
  input  wire        ref_clk,
  input  wire        line,
  input  wire  [3:0] nbits,
  input  wire        pull_rx,
  output logic       rx_pin,
  output logic [8:0] got,
  output int         frames,
  output int         bad_stop
);
  int i;
  // drives its own pin only; half duplex must ignore it
  assign rx_pin = pull_rx ? 1'b0 : 1'b1;
  initial begin
    frames = 0;
    bad_stop = 0;
    got = '0;
    forever begin
      @(negedge line);
      repeat (HALF) @(posedge ref_clk);
      if (!line) begin
        got = '0;
        for (i = 0; i < nbits; i++) begin
          repeat (2 * HALF) @(posedge ref_clk);
          got[i] = line;
        end
        repeat (2 * HALF) @(posedge ref_clk);
        if (!line) bad_stop++;
        frames++;
      end
    end
  end
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
// ******************************
// bench top
// ******************************
module tb;
  localparam logic [15:0] HB = 16'h0002;
  logic       ref_clk, rst, module_enable, transmitter_enable;
  logic       parity_enable, parity_select, half_duplex_enable;
  logic       sync_clock_out_enable, transmit_data_write, pull_rx;
  logic       break_request_set, break_request_cancel, rx_char_done;
  logic       transmit_complete_clear, parity_error_clear;
  logic       transmit_empty_irq_enable, transmit_complete_irq_enable;
  logic       parity_error_irq_enable;
  logic [1:0] word_length_select, stop_bits_select;
  logic [8:0] transmit_data_reg, rx_char, got;
  logic [3:0] nbits;
  wire        rx_pin, tx_pin_in, tx_pin_out, tx_pin_oe, tx_busy;
  wire        serial_clock_out_pin, receive_line, break_send_request;
  wire        transmit_buffer_empty_flag, transmit_complete_flag;
  wire        parity_error_flag, transmit_empty_irq;
  wire        transmit_complete_irq, parity_error_irq;
  int         frames, bad_stop, num_errors, num_checks, rises;
  // released wire floats high through the pull-up
  assign tx_pin_in = tx_pin_oe ? tx_pin_out : 1'b1;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge serial_clock_out_pin) rises++;
  stfp_tx_frame DUT (
    .ref_clk, .rst, .module_enable, .transmitter_enable,
    .word_length_select, .parity_enable, .parity_select,
    .stop_bits_select, .half_duplex_enable, .sync_clock_out_enable,
    .half_bit_divisor(HB), .transmit_data_reg, .transmit_data_write,
    .break_request_set, .break_request_cancel, .transmit_complete_clear,
    .transmit_empty_irq_enable, .transmit_complete_irq_enable, .rx_char,
    .rx_char_done, .parity_error_clear, .parity_error_irq_enable,
    .rx_pin, .tx_pin_in, .tx_pin_out, .tx_pin_oe, .serial_clock_out_pin,
    .receive_line, .break_send_request, .transmit_buffer_empty_flag,
    .transmit_complete_flag, .parity_error_flag, .transmit_empty_irq,
    .transmit_complete_irq, .parity_error_irq, .tx_busy
  );
  stfp_remote_peer #(.HALF(HB)) peer (
    .ref_clk, .line(tx_pin_in), .nbits, .pull_rx, .rx_pin, .got,
    .frames, .bad_stop
  );
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, act);
    num_checks++;
    if (exp !== act) begin
      num_errors++;
      $display("[FAIL] %s exp %0h got %0h", what, exp, act);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse_wr(input logic [8:0] d);
    @(posedge ref_clk);
    transmit_data_reg <= d;
    transmit_data_write <= 1'b1;
    @(posedge ref_clk);
    transmit_data_write <= 1'b0;
  endtask
  // bounded: a stuck engine ends the run
  task automatic wait_idle(output int n);
    n = 0;
    repeat (4) @(posedge ref_clk);
    while (tx_busy !== 1'b0) begin
      @(posedge ref_clk);
      n++;
      if (n > 3000) begin
        num_errors++;
        print_verdict;
      end
    end
    tick(2);
  endtask
  // ******************************
  // scenarios
  // ******************************
  task automatic t_enable;
    int n;
    @(posedge ref_clk);
    transmit_complete_clear <= 1'b1;
    @(posedge ref_clk);
    transmit_complete_clear <= 1'b0;
    transmitter_enable <= 1'b1; // held to the end
    wait_idle(n);
    chk("idle frame", 1, n > 20);
    chk("no start", 0, frames);
    chk("idle line", 1, tx_pin_in);
    chk("no complete", 0, transmit_complete_flag);
  endtask
  task automatic t_formats;
    logic [8:0] d, e;
    int n, nb, k;
    for (k = 0; k < 12; k++) begin
      @(posedge ref_clk);
      word_length_select <= 2'(k / 4);
      parity_enable <= k[1];
      parity_select <= k[0];
      nb = (k / 4 == 1) ? 9 : (k / 4 == 2) ? 7 : 8;
      nbits <= 4'(nb);
      d = 9'h1a5 ^ 9'(k * 37);
      e = d & 9'((1 << nb) - 1);
      if (k[1]) e[nb - 1] = ^(e & 9'((1 << (nb - 1)) - 1)) ^ k[0];
      pulse_wr(d);
      wait_idle(n);
      chk("char", e, got);
      chk("complete", 1, transmit_complete_flag);
    end
    chk("stop high", 0, bad_stop);
    chk("frames", 12, frames);
  endtask
  task automatic t_stops;
    int len[4];
    int k;
    int halves[4] = '{2, 1, 4, 3};
    for (k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      stop_bits_select <= 2'(k);
      pulse_wr(9'h0f0);
      wait_idle(len[k]);
    end
    for (k = 1; k < 4; k++) begin
      chk("stop len", (halves[k] - 2) * HB, len[k] - len[0]);
    end
    @(posedge ref_clk);
    stop_bits_select <= 2'b00;
    word_length_select <= 2'b00;
    parity_enable <= 1'b0;
    nbits <= 4'h8;
  endtask
  task automatic t_b2b;
    int n, f;
    f = frames;
    pulse_wr(9'h03c);
    tick(0);
    chk("empty low", 0, transmit_buffer_empty_flag);
    tick(1);
    chk("direct load", 1, transmit_buffer_empty_flag);
    pulse_wr(9'h0c3);
    tick(3);
    chk("held", 0, transmit_buffer_empty_flag);
    chk("not done", 0, transmit_complete_flag);
    wait_idle(n);
    wait_idle(n);
    chk("two frames", f + 2, frames);
    chk("second", 9'h0c3, got);
  endtask
  task automatic t_break;
    int n, f, b;
    f = frames;
    b = bad_stop;
    @(posedge ref_clk);
    break_request_set <= 1'b1;
    @(posedge ref_clk);
    break_request_set <= 1'b0;
    tick(1);
    chk("break req", 1, break_send_request);
    wait_idle(n);
    chk("break zeros", 0, got);
    chk("break stop", b, bad_stop);
    chk("req cleared", 0, break_send_request);
    pulse_wr(9'h055);
    tick(4);
    @(posedge ref_clk);
    break_request_set <= 1'b1;
    @(posedge ref_clk);
    break_request_set <= 1'b0;
    break_request_cancel <= 1'b1;
    @(posedge ref_clk);
    break_request_cancel <= 1'b0;
    wait_idle(n);
    wait_idle(n);
    chk("cancelled", f + 2, frames);
    chk("last char", 9'h055, got);
  endtask
  task automatic t_clock;
    int n;
    @(posedge ref_clk);
    sync_clock_out_enable <= 1'b1;
    rises = 0;
    pulse_wr(9'h0a5);
    wait_idle(n);
    chk("clock pulses", 8, rises);
    @(posedge ref_clk);
    sync_clock_out_enable <= 1'b0;
  endtask
  task automatic t_half;
    int n;
    @(posedge ref_clk);
    half_duplex_enable <= 1'b1;
    pull_rx <= 1'b1;
    tick(6);
    chk("rx ignored", 1, receive_line);
    pulse_wr(9'h0b4);
    wait_idle(n);
    chk("open drain", 9'h0b4, got);
    @(posedge ref_clk);
    half_duplex_enable <= 1'b0;
    tick(6);
    chk("rx used", 0, receive_line);
    @(posedge ref_clk);
    pull_rx <= 1'b0;
  endtask
  task automatic t_parity;
    @(posedge ref_clk);
    parity_enable <= 1'b1;
    parity_select <= 1'b0;
    rx_char <= 9'h001;
    rx_char_done <= 1'b1; // transmitter idle here
    @(posedge ref_clk);
    rx_char_done <= 1'b0;
    tick(2);
    chk("parity err", 1, parity_error_flag);
    chk("parity irq", 1, parity_error_irq);
    @(posedge ref_clk);
    parity_error_clear <= 1'b1;
    rx_char <= 9'h003;
    @(posedge ref_clk);
    parity_error_clear <= 1'b0;
    rx_char_done <= 1'b1;
    @(posedge ref_clk);
    rx_char_done <= 1'b0;
    tick(2);
    chk("parity ok", 0, parity_error_flag);
  endtask
  initial begin
    {ref_clk, transmitter_enable, parity_enable, parity_select,
     half_duplex_enable, sync_clock_out_enable, transmit_data_write,
     break_request_set, break_request_cancel, transmit_complete_clear,
     rx_char_done, parity_error_clear, pull_rx, word_length_select,
     stop_bits_select, transmit_data_reg, rx_char} = '0;
    rst = 1'b1;
    module_enable = 1'b1;
    transmit_empty_irq_enable = 1'b1;
    transmit_complete_irq_enable = 1'b1;
    parity_error_irq_enable = 1'b1;
    nbits = 4'h8;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    tick(1);
    chk("empty at reset", 1, transmit_buffer_empty_flag);
    t_enable();
    t_formats();
    t_stops();
    t_b2b();
    t_break();
    t_clock();
    t_half();
    t_parity();
    chk("complete at end", 1, transmit_complete_flag);
    print_verdict();
  end
endmodule
